// file: inc/dcl_params.svh
// dcl_params.svh: byte codes, field positions and timing counts of the
// daisy-chain one-wire link.
// assumes: included by bare name from the link modules; the package does not include it.
`ifndef DCL_PARAMS_SVH
`define DCL_PARAMS_SVH

`define DCL_CMD_ADDR_INIT 8'h95
`define DCL_CMD_LAST_POLL 8'h57
`define DCL_CMD_SOFT_RST 8'h5D
`define DCL_CMD_ALERT_CLR1 8'hB5
`define DCL_CMD_ALERT_CLR2 8'h75
`define DCL_CAL_FALLS 3'h4
`define DCL_CAL_SHIFT 3
`define DCL_GAP_SHIFT 4
`define DCL_RESET_ADDR 5'h00
`define DCL_ADDR_MAX 5'h1F
`define DCL_ADDR_RESP_LOW 3'h5
`define DCL_WORD_LAST 4'h9
`define DCL_DATA_LAST 3'h7

`endif

// file: inc/dcl_pkg.sv
// dcl_pkg: types shared by the one-wire link front end.
// assumes: nothing beyond a SystemVerilog compiler.
package dcl_pkg;

  typedef enum logic [3:0] {
    ST_WAIT, ST_CMD, ST_PTR, ST_WDATA, ST_ASSIGN, ST_REPLY, ST_RELAY
  } dcl_mode_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_CAL, RX_START, RX_DATA, RX_STOP
  } dcl_rx_st_t;

  typedef struct packed {
    logic [4:0] code;
    logic command_not_address;
    logic read_not_write;
    logic global_select;
  } dcl_cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [15:0] wdata;
  } dcl_reg_req_t;

  typedef struct packed {
    logic wr;
    logic [4:0] addr;
  } dcl_nv_t;

endpackage

// file: logic/dcl_rx.sv
// dcl_rx: word receiver with baud calibration from the 55h word.
// assumes: line input synchronous to ref_clk_i, idle high.
`timescale 1ns/10ps
`default_nettype none
`include "dcl_params.svh"

module dcl_rx (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic line_i,
  input wire logic cal_i,
  output logic byte_vld_o,
  output logic [7:0] byte_o,
  output logic cal_done_o,
  output logic [15:0] period_o
);
  import dcl_pkg::*;

  typedef struct packed {
    dcl_rx_st_t st;
    logic [18:0] cnt;
    logic [2:0] edges;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [15:0] per;
    logic prev;
    logic vld;
    logic cal_done;
    logic [7:0] data;
  } dcl_rx_state_t;

  dcl_rx_state_t q, d;
  logic fall;
  logic [18:0] full;
  logic [18:0] half;

  assign fall = q.prev & ~line_i;
  assign full = {3'h0, q.per};
  assign half = {4'h0, q.per[15:1]};

  always_comb begin
    d = q;
    d.vld = 1'b0;
    d.cal_done = 1'b0;
    d.prev = line_i;
    d.cnt = q.cnt + 19'h1;
    case (q.st)
      RX_IDLE: if (fall) begin
        d.cnt = 19'h0;
        d.edges = 3'h0;
        d.st = cal_i ? RX_CAL : RX_START;
      end
      RX_CAL: begin
        // eight bit times span the first to the fifth falling edge
        if (fall) begin
          d.edges = q.edges + 3'h1;
          if (d.edges == `DCL_CAL_FALLS) begin
            d.per = 16'(d.cnt >> `DCL_CAL_SHIFT);
            d.cal_done = 1'b1;
            d.st = RX_IDLE;
          end
        end else if (d.cnt == 19'h0) begin
          d.st = RX_IDLE;
        end
      end
      RX_START: if (d.cnt >= half) begin
        d.cnt = 19'h0;
        d.bitn = 3'h0;
        d.st = line_i ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (d.cnt >= full) begin
        d.cnt = 19'h0;
        d.sh = {line_i, q.sh[7:1]};
        d.bitn = q.bitn + 3'h1;
        if (q.bitn == `DCL_DATA_LAST) d.st = RX_STOP;
      end
      RX_STOP: if (d.cnt >= full) begin
        d.st = RX_IDLE;
        if (line_i) begin
          d.vld = 1'b1;
          d.data = q.sh;
        end
      end
      default: d.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) q <= '0;
    else q <= d;
  end

  assign byte_vld_o = q.vld;
  assign byte_o = q.data;
  assign cal_done_o = q.cal_done;
  assign period_o = q.per;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_cal_period;
    q.cal_done |-> q.per == 16'($past(q.cnt + 19'h1) >> 3);
  endproperty
  a_cal_period: assert property (p_cal_period)
    else $error("calibrated period not one eighth of span");

  property p_stop_high;
    q.vld |-> $past(line_i) && $past(q.st) == RX_STOP;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("word accepted without high stop bit");
endmodule
`default_nettype wire

// file: logic/dcl_tx.sv
// dcl_tx: ten-bit word transmitter, start low, lsb first, stop high.
// assumes: period_i stays steady while a word is sent.
`timescale 1ns/10ps
`default_nettype none
`include "dcl_params.svh"

module dcl_tx (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] period_i,
  output logic line_o,
  output logic done_o
);
  import dcl_pkg::*;

  typedef struct packed {
    logic run;
    logic [8:0] sh;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic line;
    logic done;
  } dcl_tx_state_t;

  dcl_tx_state_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.run) begin
      d.line = 1'b1;
      if (start_i) begin
        d.run = 1'b1;
        d.sh = {1'b1, byte_i};
        d.cnt = 16'h0;
        d.bitn = 4'h0;
        d.line = 1'b0;
      end
    end else begin
      d.cnt = q.cnt + 16'h1;
      if (d.cnt >= period_i) begin
        d.cnt = 16'h0;
        d.bitn = q.bitn + 4'h1;
        if (q.bitn == `DCL_WORD_LAST) begin
          d.run = 1'b0;
          d.done = 1'b1;
          d.line = 1'b1;
        end else begin
          d.line = q.sh[0];
          d.sh = {1'b0, q.sh[8:1]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) q <= '0;
    else q <= d;
  end

  assign line_o = q.line;
  assign done_o = q.done;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_start_low;
    !q.run && start_i |=> !line_o && q.run;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("word did not open with low start bit");

  property p_stop_then_done;
    done_o |-> $past(line_o) && line_o;
  endproperty
  a_stop_then_done: assert property (p_stop_then_done)
    else $error("word ended without high stop level");
endmodule
`default_nettype wire

// file: logic/dcl_link.sv
// dcl_link: protocol front end of a daisy-chained one-wire sensor link.
// assumes: line inputs are the resolved wire levels, synchronous to clock.
`timescale 1ns/10ps
`default_nettype none
`include "dcl_params.svh"

module dcl_link (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic upstream_line_i,
  output logic upstream_line_o,
  output logic upstream_line_oe_o,
  input wire logic downstream_line_i,
  output logic downstream_line_o,
  output logic downstream_line_oe_o,
  input wire logic [4:0] nv_addr_i,
  input wire logic last_device_i,
  input wire logic [15:0] reg_rdata_i,
  output dcl_pkg::dcl_reg_req_t reg_req_o,
  output dcl_pkg::dcl_nv_t nv_wr_o,
  output logic soft_reset_o,
  output logic [1:0] alert_clear_o,
  output logic [4:0] device_address_o,
  output dcl_pkg::dcl_mode_t mode_o
);
  import dcl_pkg::*;

  typedef struct packed {
    dcl_mode_t mode;
    dcl_cmd_t cmd;
    logic loaded;
    logic [4:0] my_addr;
    logic byte1;
    logic [19:0] gap;
    logic pend;
    logic fill;
    logic then_relay;
    logic [1:0][7:0] txb;
    logic [1:0] txdn;
    logic seq;
    logic tx_n;
    logic tx_go;
    logic tx_act;
    logic up_o;
    logic up_oe;
    logic dn_o;
    logic dn_oe;
    dcl_reg_req_t req;
    dcl_nv_t nv;
    logic srst;
    logic [1:0] aclr;
  } dcl_state_t;

  dcl_state_t q, d;
  logic rx_vld;
  logic [7:0] rx_byte;
  logic cal_done;
  logic [15:0] period;
  logic tx_line;
  logic tx_done;
  dcl_cmd_t rx_cmd;
  logic [19:0] gap_lim;
  logic [19:0] half;
  logic hit_eq;
  logic hit_le;
  logic fwd;

  assign rx_cmd = dcl_cmd_t'(rx_byte);
  assign gap_lim = {period, 4'h0};
  assign half = {5'h0, period[15:1]};
  // individual target or highest covered address
  assign hit_eq = q.my_addr == q.cmd.code;
  assign hit_le = q.my_addr <= q.cmd.code;
  assign fwd = q.mode == ST_WAIT || q.mode == ST_CMD ||
               q.mode == ST_PTR || q.mode == ST_WDATA;

  dcl_rx u_rx (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .line_i(upstream_line_i),
    .cal_i(q.mode == ST_WAIT),
    .byte_vld_o(rx_vld),
    .byte_o(rx_byte),
    .cal_done_o(cal_done),
    .period_o(period)
  );
  dcl_tx u_tx (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(q.tx_go),
    .byte_i(q.txb[q.seq]),
    .period_i(period),
    .line_o(tx_line),
    .done_o(tx_done)
  );
  always_comb begin
    d = q;
    d.tx_go = 1'b0;
    d.req.wr = 1'b0;
    d.req.rd = 1'b0;
    d.nv.wr = 1'b0;
    d.srst = 1'b0;
    d.aclr = 2'h0;
    if (!upstream_line_i || !downstream_line_i) d.gap = 20'h0;
    else if (q.gap != 20'hFFFFF) d.gap = q.gap + 20'h1;
    if (!q.loaded) begin
      d.loaded = 1'b1;
      d.my_addr = nv_addr_i;
    end
    case (q.mode)
      ST_WAIT: if (cal_done) begin
        d.mode = ST_CMD;
        d.gap = 20'h0;
      end
      ST_CMD: if (rx_vld) begin
        d.cmd = rx_cmd;
        if (!rx_cmd.command_not_address) begin
          d.mode = ST_PTR;
        end else begin
          d.mode = ST_WAIT;
          d.fill = 1'b0;
          d.then_relay = 1'b0;
          d.seq = 1'b0;
          d.tx_n = 1'b0;
          d.txdn = 2'h0;
          case (rx_byte)
            `DCL_CMD_ADDR_INIT: d.mode = ST_ASSIGN;
            `DCL_CMD_LAST_POLL: begin
              d.txb[0] = {q.my_addr, `DCL_ADDR_RESP_LOW};
              d.mode = last_device_i ? ST_REPLY : ST_RELAY;
              d.pend = 1'b0;
              d.gap = 20'h0;
            end
            `DCL_CMD_SOFT_RST: begin
              d.srst = 1'b1;
              d.my_addr = nv_addr_i;
            end
            `DCL_CMD_ALERT_CLR1: d.aclr = 2'h1;
            `DCL_CMD_ALERT_CLR2: d.aclr = 2'h2;
            default: d.mode = ST_WAIT;
          endcase
        end
      end
      ST_PTR: if (rx_vld) begin
        d.req.ptr = rx_byte;
        d.byte1 = 1'b0;
        d.gap = 20'h0;
        d.pend = 1'b0;
        d.fill = 1'b1;
        d.then_relay = 1'b0;
        d.seq = 1'b0;
        d.tx_n = 1'b1;
        d.txdn = 2'h0;
        if (!q.cmd.read_not_write) begin
          d.fill = 1'b0;
          d.mode = ST_WDATA;
        end else if (hit_eq) begin
          d.req.rd = 1'b1;
          d.mode = ST_REPLY;
        end else if (q.cmd.global_select && hit_le) begin
          // nearer devices answer after the farther ones
          d.req.rd = 1'b1;
          d.pend = 1'b1;
          d.mode = ST_RELAY;
        end else begin
          d.fill = 1'b0;
          d.mode = q.cmd.global_select ? ST_WAIT : ST_RELAY;
        end
      end
      ST_WDATA: if (rx_vld) begin
        if (!q.byte1) begin
          d.req.wdata[7:0] = rx_byte;
          d.byte1 = 1'b1;
        end else begin
          d.req.wdata[15:8] = rx_byte;
          d.req.wr = q.cmd.global_select ? hit_le : hit_eq;
          d.mode = ST_WAIT;
        end
      end
      ST_ASSIGN: if (rx_vld) begin
        // take own address, report up, hand next one down unless own address is 1Fh
        d.my_addr = rx_byte[7:3];
        d.nv.wr = 1'b1;
        d.nv.addr = rx_byte[7:3];
        d.txb[0] = {rx_byte[7:3], `DCL_ADDR_RESP_LOW};
        d.txb[1] = {rx_byte[7:3] + 5'h1, rx_byte[2:0]};
        d.txdn = 2'h2;
        d.tx_n = rx_byte[7:3] != `DCL_ADDR_MAX;
        d.fill = 1'b0;
        d.then_relay = 1'b1;
        d.seq = 1'b0;
        d.gap = 20'h0;
        d.mode = ST_REPLY;
      end
      ST_REPLY: begin
        // first word after half a bit, well inside the limit
        if (!q.tx_act && (q.seq || q.gap >= half)) begin
          d.tx_go = 1'b1;
          d.tx_act = 1'b1;
          if (q.fill && !q.seq) begin
            d.txb = reg_rdata_i;
            d.fill = 1'b0;
          end
        end
        if (tx_done) begin
          d.tx_act = 1'b0;
          d.seq = 1'b1;
          if (q.seq == q.tx_n) begin
            d.seq = 1'b0;
            d.gap = 20'h0;
            d.mode = q.then_relay ? ST_RELAY : ST_WAIT;
          end
        end
      end
      default: ;
    endcase
    if (q.mode != ST_WAIT && q.mode != ST_REPLY && q.gap >= gap_lim) begin
      d.gap = 20'h0;
      d.mode = (q.mode == ST_RELAY && q.pend) ? ST_REPLY : ST_WAIT;
      d.pend = 1'b0;
    end
    // line drive, high when released
    d.dn_oe = fwd || (q.mode == ST_REPLY && q.tx_act && q.txdn[q.seq]);
    d.dn_o = fwd ? upstream_line_i :
             (q.txdn[q.seq] && q.tx_act ? tx_line : 1'b1);
    d.up_oe = q.mode == ST_RELAY ||
              (q.mode == ST_REPLY && q.tx_act && !q.txdn[q.seq]);
    d.up_o = q.mode == ST_RELAY ? downstream_line_i :
             (!q.txdn[q.seq] && q.tx_act ? tx_line : 1'b1);
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.my_addr <= `DCL_RESET_ADDR;
    end else begin
      q <= d;
    end
  end
  assign upstream_line_o = q.up_o;
  assign upstream_line_oe_o = q.up_oe;
  assign downstream_line_o = q.dn_o;
  assign downstream_line_oe_o = q.dn_oe;
  assign reg_req_o = q.req;
  assign nv_wr_o = q.nv;
  assign soft_reset_o = q.srst;
  assign alert_clear_o = q.aclr;
  assign device_address_o = q.my_addr;
  assign mode_o = q.mode;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_quiet_up;
    $past(reset_n_i) && $past(q.mode) == ST_WAIT |->
      !upstream_line_oe_o && upstream_line_o;
  endproperty
  a_quiet_up: assert property (p_quiet_up)
    else $error("upstream driven while waiting for host");
  property p_forward;
    $past(reset_n_i) && $past(q.mode) == ST_WAIT |->
      downstream_line_oe_o && downstream_line_o == $past(upstream_line_i);
  endproperty
  a_forward: assert property (p_forward)
    else $error("host traffic not forwarded downstream");
  property p_recal;
    q.mode == ST_WAIT && cal_done |=> q.mode == ST_CMD;
  endproperty
  a_recal: assert property (p_recal)
    else $error("calibration word did not open operation");
  property p_kind;
    q.mode == ST_CMD && rx_vld |=>
      (q.mode == ST_PTR) == !$past(rx_cmd.command_not_address);
  endproperty
  a_kind: assert property (p_kind)
    else $error("pointer phase taken for wrong operation kind");
  property p_soft_rst;
    q.mode == ST_CMD && rx_vld && rx_byte == `DCL_CMD_SOFT_RST |=>
      soft_reset_o && device_address_o == $past(nv_addr_i);
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset command not applied");
  property p_reserved;
    q.mode == ST_CMD && rx_vld && rx_cmd.command_not_address &&
      rx_byte != `DCL_CMD_ADDR_INIT && rx_byte != `DCL_CMD_LAST_POLL &&
      rx_byte != `DCL_CMD_SOFT_RST && rx_byte != `DCL_CMD_ALERT_CLR1 &&
      rx_byte != `DCL_CMD_ALERT_CLR2 |=>
      q.mode == ST_WAIT && !soft_reset_o && alert_clear_o == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved command code acted upon");
  property p_gwrite;
    q.mode == ST_WDATA && rx_vld && q.byte1 && q.cmd.global_select &&
      q.my_addr <= q.cmd.code |=>
      reg_req_o.wr && reg_req_o.wdata[15:8] == $past(rx_byte);
  endproperty
  a_gwrite: assert property (p_gwrite)
    else $error("global write not applied in range");
  property p_write_dir;
    q.mode == ST_PTR && rx_vld && !q.cmd.read_not_write |=>
      q.mode == ST_WDATA && !reg_req_o.rd;
  endproperty
  a_write_dir: assert property (p_write_dir)
    else $error("write operation took read path");
  sequence s_read_hit;
    q.mode == ST_PTR && rx_vld && q.cmd.read_not_write &&
      !q.cmd.global_select && q.my_addr == q.cmd.code;
  endsequence
  sequence s_reply_armed;
    reg_req_o.rd && q.mode == ST_REPLY ##1 !reg_req_o.rd;
  endsequence
  property p_read_hit;
    s_read_hit |=> s_reply_armed;
  endproperty
  a_read_hit: assert property (p_read_hit)
    else $error("matching individual read not answered");
endmodule
`default_nettype wire

// file: sim/dcl_host_model.sv
// dcl_host_model: behavioural host controller for the one-wire link.
// assumes: bench resolves the wires, both pulled high when released.
`timescale 1ns/10ps
`default_nettype none

module dcl_host_model (
  input wire logic ref_clk_i,
  input wire logic up_i,
  input wire logic dn_i,
  output logic drv_o
);
  // host released at rest
  initial drv_o = 1'b1;

  // start low, data lsb first, stop high, p cycles a bit
  task automatic send(input logic [7:0] b, input int p);
    drv_o = 1'b0;
    repeat (p) @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      drv_o = b[i];
      repeat (p) @(negedge ref_clk_i);
    end
    drv_o = 1'b1;
    repeat (p) @(negedge ref_clk_i);
  endtask

  // bounded wait for a start bit, then centre sampling
  task automatic recv(input bit sel, input int p, output logic [7:0] b,
                      output logic ok, output int waited);
    waited = 0;
    b = 8'h00;
    while ((sel ? dn_i : up_i) !== 1'b0 && waited < 40 * p) begin
      @(negedge ref_clk_i);
      waited++;
    end
    ok = (waited < 40 * p);
    if (!ok) return;
    repeat (p / 2) @(negedge ref_clk_i);
    ok = ((sel ? dn_i : up_i) === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (p) @(negedge ref_clk_i);
      b[i] = sel ? dn_i : up_i;
    end
    repeat (p) @(negedge ref_clk_i);
    ok = ok && ((sel ? dn_i : up_i) === 1'b1);
  endtask
endmodule
`default_nettype wire

// file: sim/dcl_link_tb.sv
// dcl_link_tb: self-checking bench for the link front end.
// assumes: host model upstream, nothing driving the far side.
`timescale 1ns/10ps
`default_nettype none

module dcl_link_tb;
  import dcl_pkg::*;
  logic ref_clk_i;
  logic reset_n_i;
  logic up_o, up_oe, dn_o, dn_oe, last_device_i, host_drv, soft_reset_o;
  logic pu;
  logic [4:0] nv_addr_i, device_address_o, nv_seen;
  logic [15:0] reg_rdata_i, wr_seen;
  logic [1:0] alert_clear_o;
  logic [7:0] rb;
  logic ok;
  dcl_reg_req_t reg_req_o;
  dcl_nv_t nv_wr_o;
  dcl_mode_t mode_o;
  dcl_mode_t pm = ST_WAIT;
  wire logic up_w;
  wire logic dn_w;
  int fails = 0;
  int checks_done = 0;
  int n_wr = 0, n_rd = 0, n_sr = 0, n_a1 = 0, n_a2 = 0, n_nv = 0, n_fw = 0;
  int lat, lat2;
  logic [7:0] wc [4] = '{8'h38, 8'h30, 8'h39, 8'h29};
  logic [15:0] wd [4] = '{16'h1111, 16'h1234, 16'h5A6B, 16'h7C8D};
  int wn [4] = '{0, 1, 2, 2};
  logic [7:0] cc [3] = '{8'h5D, 8'hB5, 8'h75};

  // pulled-up wires
  assign up_w = host_drv & (up_oe ? up_o : 1'b1);
  assign dn_w = dn_oe ? dn_o : 1'b1;

  dcl_link dcl_link_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .upstream_line_i(up_w), .upstream_line_o(up_o),
    .upstream_line_oe_o(up_oe), .downstream_line_i(dn_w),
    .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe),
    .nv_addr_i(nv_addr_i), .last_device_i(last_device_i),
    .reg_rdata_i(reg_rdata_i), .reg_req_o(reg_req_o), .nv_wr_o(nv_wr_o),
    .soft_reset_o(soft_reset_o), .alert_clear_o(alert_clear_o),
    .device_address_o(device_address_o), .mode_o(mode_o)
  );

  dcl_host_model dcl_host_model_inst (
    .ref_clk_i(ref_clk_i), .up_i(up_w), .dn_i(dn_w), .drv_o(host_drv)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // pulse counters and one-cycle-late forwarding watch
  always @(posedge ref_clk_i) begin
    pm <= mode_o;
    pu <= up_w;
    if (reg_req_o.wr === 1'b1) begin
      n_wr++;
      wr_seen <= reg_req_o.wdata;
    end
    if (reg_req_o.rd === 1'b1) n_rd++;
    if (soft_reset_o === 1'b1) n_sr++;
    if (alert_clear_o[0] === 1'b1) n_a1++;
    if (alert_clear_o[1] === 1'b1) n_a2++;
    if (nv_wr_o.wr === 1'b1) begin
      n_nv++;
      nv_seen <= nv_wr_o.addr;
    end
    if (reset_n_i && dn_oe && pm <= ST_WDATA && mode_o <= ST_WDATA &&
        dn_o !== pu) n_fw++;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [4:0] nv);
    @(negedge ref_clk_i);
    reset_n_i = 1'b0;
    nv_addr_i = nv;
    repeat (20) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic idle(input int p);
    repeat (20 * p) @(negedge ref_clk_i);
  endtask

  // calibration word, then n bytes of w, lowest first
  task automatic op(input int p, input int n, input logic [31:0] w);
    @(negedge ref_clk_i);
    dcl_host_model_inst.send(8'h55, p);
    for (int i = 0; i < n; i++) begin
      dcl_host_model_inst.send(w[8 * i +: 8], p);
    end
  endtask

  task automatic expect_word(input string name, input bit sel, input int p,
                             input logic [7:0] exp, output int waited);
    logic [7:0] b;
    logic k;
    dcl_host_model_inst.recv(sel, p, b, k, waited);
    check(name, {8'h00, b}, {8'h00, exp});
    if (k !== 1'b1) begin
      check({name, "_frame"}, 16'(k), 16'h0001);
      summarize();
    end
  endtask

  initial begin
    reset_n_i = 1'b0;
    nv_addr_i = 5'h06;
    last_device_i = 1'b1;
    reg_rdata_i = 16'hA5C3;
    do_reset(5'h06);
    check("mode", 16'(mode_o), 16'(ST_WAIT));
    check("address", 16'(device_address_o), 16'h0006);
    check("up_oe", 16'(up_oe), 16'h0000);
    check("dn_oe", 16'(dn_oe), 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      op(16, 4, {wd[i], 8'h0A, wc[i]});
      idle(16);
      check("wr_count", 16'(n_wr), 16'(wn[i]));
    end
    check("wr_ptr", 16'(reg_req_o.ptr), 16'h000A);
    check("wr_data", wr_seen, wd[2]);
    $display("test write done");
    op(24, 2, 32'h0000_0332);
    expect_word("rd_low", 1'b0, 24, 8'hC3, lat);
    check("rd_latency", 16'(lat > 24 * 3 / 2), 16'h0000);
    expect_word("rd_high", 1'b0, 24, 8'hA5, lat);
    check("rd_count", 16'(n_rd), 16'h0001);
    check("rd_ptr", 16'(reg_req_o.ptr), 16'h0003);
    idle(24);
    $display("test read done");
    op(16, 0, 32'h0);
    repeat (4) @(negedge ref_clk_i);
    check("mode_cal", 16'(mode_o), 16'(ST_CMD));
    dcl_host_model_inst.send(8'hFD, 16);
    repeat (4) @(negedge ref_clk_i);
    check("mode_rsvd", 16'(mode_o), 16'(ST_WAIT));
    idle(16);
    for (int i = 0; i < 3; i++) begin
      op(16, 1, {24'h0, cc[i]});
      repeat (4) @(negedge ref_clk_i);
      check("no_ptr", 16'(mode_o == ST_PTR), 16'h0000);
      idle(16);
    end
    check("soft_reset", 16'(n_sr), 16'h0001);
    check("alert1", 16'(n_a1), 16'h0001);
    check("alert2", 16'(n_a2), 16'h0001);
    check("cmd_no_req", 16'(n_wr + n_rd), 16'h0003);
    op(16, 1, 32'h57);
    expect_word("poll", 1'b0, 16, 8'h35, lat);
    idle(16);
    last_device_i = 1'b0;
    op(16, 1, 32'h57);
    dcl_host_model_inst.recv(1'b0, 16, rb, ok, lat);
    check("poll_quiet", 16'(ok), 16'h0000);
    idle(16);
    $display("test command done");
    op(16, 2, 32'h1D95);
    fork
      expect_word("assign_up", 1'b0, 16, 8'h1D, lat);
      expect_word("assign_dn", 1'b1, 16, 8'h25, lat2);
    join
    idle(16);
    check("nv_count", 16'(n_nv), 16'h0001);
    check("nv_addr", 16'(nv_seen), 16'h0003);
    do_reset(5'h0B);
    check("reload", 16'(device_address_o), 16'h000B);
    check("forward", 16'(n_fw), 16'h0000);
    $display("test assign done");
    summarize();
  end
endmodule
`default_nettype wire
